// ===== src/pxg_pkg.sv
// constants shared by the port crossbar and its helpers
// assumes a byte-addressed avalon slave with 32-bit words
package pxg_pkg;
    // ---------------------------------------------
    // sizes
    // ---------------------------------------------
    localparam int NUM_PORTS = 4;
    localparam int PORT_W = 8;
    localparam int NUM_PINS = 32;
    localparam int NUM_FN = 8;
    localparam int ADDR_W = 7;

    // ---------------------------------------------
    // register byte offsets
    // ---------------------------------------------
    localparam logic [6:0] OFS_DATA0 = 7'h00;  // port data, four words
    localparam logic [6:0] OFS_MODE0 = 7'h10;  // port_output_mode_reg, four words
    localparam logic [6:0] OFS_CFG0 = 7'h20;   // peripheral enables
    localparam logic [6:0] OFS_CFG1 = 7'h24;   // spi wiring
    localparam logic [6:0] OFS_CFG2 = 7'h28;   // crossbar_config_third
    localparam logic [6:0] OFS_LATCH0 = 7'h30; // latch read-back, four words
    localparam logic [6:0] OFS_BIT = 7'h40;    // single-bit latch write
    localparam logic [2:0] GRP_DATA = 3'h0;
    localparam logic [2:0] GRP_MODE = 3'h1;
    localparam logic [2:0] GRP_CFG = 3'h2;
    localparam logic [2:0] GRP_LATCH = 3'h3;
    localparam logic [2:0] GRP_BIT = 3'h4;

    // ---------------------------------------------
    // field positions
    // ---------------------------------------------
    localparam int CFG0_SMB_POS = 0;
    localparam int CFG0_SPI_POS = 1;
    localparam int CFG0_UART_POS = 2;
    localparam int CFG1_SPI4_POS = 0;
    localparam int XBE_POS = 4;        // crossbar_enable_bit
    localparam int BIT_VAL_POS = 8;    // value of a single-bit write

    // ---------------------------------------------
    // reset values
    // ---------------------------------------------
    localparam logic [31:0] LATCH_RST = 32'hffffffff;
    localparam logic [31:0] MODE_RST = 32'h00000000;
    localparam logic [7:0] CFG_RST = 8'h00;

    // ---------------------------------------------
    // crossbar functions in priority order
    // ---------------------------------------------
    typedef enum logic [2:0] {
        FN_SDA = 3'h0, FN_SCL = 3'h1, FN_SCK = 3'h2, FN_MISO = 3'h3,
        FN_MOSI = 3'h4, FN_SSEL = 3'h5, FN_TX = 3'h6, FN_RX = 3'h7
    } pxg_fn_t;
    localparam logic [7:0] FN_INPUT_ONLY = 8'h80;  // uart_a_receive only

    typedef enum logic {
        BUS_WAIT = 1'b0,
        BUS_ACK = 1'b1
    } pxg_bus_t;
endpackage

// ===== src/pxg_pin_sync.sv
// three-stage pin synchroniser with agreement filter
// assumes asynchronous pin levels and one system clock
`timescale 1ns/1ps
module pxg_pin_sync #(
    parameter int W = 32
) (
    input wire logic ref_clk,       // system clock
    input wire logic sys_rst,       // synchronous reset, high
    input wire logic [W-1:0] din,   // raw pin levels
    output logic [W-1:0] dout       // filtered levels
);
    logic [W-1:0] s1_q, s2_q, s3_q, lvl_q, lvl_d;

    // ---------------------------------------------
    // agreement filter
    // ---------------------------------------------
    // the level moves only when stage two and three agree
    always_comb begin
        lvl_d = (~(s2_q ^ s3_q) & s3_q) | ((s2_q ^ s3_q) & lvl_q);
    end

    // stage one is read by stage two only
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
            lvl_q <= '0;
        end else begin
            s1_q <= din;
            s2_q <= s1_q;
            s3_q <= s2_q;
            lvl_q <= lvl_d;
        end
    end

    assign dout = lvl_q;
endmodule

// ===== src/pxg_xbar_map.sv
// crossbar map: enabled functions to pins in priority order
// assumes enable bits come from registers on the same clock
`timescale 1ns/1ps
module pxg_xbar_map import pxg_pkg::*; (
    input wire logic en_smb,                  // two-wire bus enable
    input wire logic en_spi,                  // spi enable
    input wire logic spi_four,                // spi with spi_slave_select
    input wire logic en_uart,                 // uart enable
    output logic [NUM_FN-1:0] fn_hit,         // function has a pin
    output logic [4:0] fn_pin [NUM_FN],       // pin of each function
    output logic [NUM_PINS-1:0] pin_hit,      // pin claimed
    output logic [2:0] pin_fn [NUM_PINS]      // function on each pin
);
    logic [NUM_FN-1:0] fn_en;
    logic [4:0] pos [NUM_FN+1];

    // whole peripherals only; slave select joins in four-wire mode
    assign fn_en = {en_uart, en_uart, en_spi & spi_four, en_spi,
                    en_spi, en_spi, en_smb, en_smb};
    assign pos[0] = 5'h00;

    // ---------------------------------------------
    // positions by prefix count
    // ---------------------------------------------
    for (genvar f = 0; f < NUM_FN; f++) begin : g_fn
        assign pos[f+1] = pos[f] + {4'h0, fn_en[f]};
        assign fn_pin[f] = pos[f];
        assign fn_hit[f] = fn_en[f];
    end

    // ---------------------------------------------
    // inverse map per pin
    // ---------------------------------------------
    for (genvar p = 0; p < NUM_PINS; p++) begin : g_pin
        logic hit;
        logic [2:0] fn;
        // an unclaimed pin falls through to gpio
        always_comb begin
            hit = 1'b0;
            fn = 3'h0;
            for (int f = 0; f < NUM_FN; f++) begin
                if (fn_en[f] && pos[f] == 5'(p)) begin
                    hit = 1'b1;
                    fn = 3'(f);
                end
            end
        end
        assign pin_hit[p] = hit;
        assign pin_fn[p] = fn;
    end
endmodule

// ===== src/pxg_port_crossbar.sv
// port i/o for ports 0 to 3 with peripheral crossbar
// assumes an avalon-mm master on ref_clk and peripherals on ref_clk
//
// The implementer's own choices: the Avalon-MM slave port and the register addresses.
`timescale 1ns/1ps
module pxg_port_crossbar import pxg_pkg::*; (
    input wire logic ref_clk,                   // system clock, 200 MHz
    input wire logic sys_rst,                   // synchronous reset, high
    input wire logic [ADDR_W-1:0] avs_address,  // byte address
    input wire logic avs_read,                  // read request
    input wire logic avs_write,                 // write request
    input wire logic [31:0] avs_writedata,      // write data
    input wire logic [3:0] avs_byteenable,      // byte lanes
    output logic [31:0] avs_readdata,           // read data
    output logic avs_waitrequest,               // stall
    input wire logic [NUM_PINS-1:0] pin_in,     // pin levels
    output logic [NUM_PINS-1:0] pin_out,        // pin drive value
    output logic [NUM_PINS-1:0] pin_oe,         // pin drive enable
    input wire logic [NUM_FN-1:0] fn_out,       // peripheral outputs
    input wire logic [NUM_FN-1:0] fn_oe,        // peripheral drive requests
    output logic [NUM_FN-1:0] fn_in             // levels to peripherals
);
    // ---------------------------------------------
    // state
    // ---------------------------------------------
    pxg_bus_t bus_q, bus_d;
    logic wait_q, wait_d;
    logic [31:0] rdata_q, rdata_d;
    logic [31:0] latch_q, latch_d;
    logic [31:0] mode_q, mode_d;
    logic [7:0] cfg0_q, cfg0_d;
    logic [7:0] cfg1_q, cfg1_d;
    logic [7:0] crossbar_config_third_q, crossbar_config_third_d;
    logic [NUM_PINS-1:0] out_q, out_d;
    logic [NUM_PINS-1:0] oe_q, oe_d;
    logic [NUM_FN-1:0] fin_q, fin_d;

    // ---------------------------------------------
    // derived signals
    // ---------------------------------------------
    logic [NUM_PINS-1:0] pin_lvl;
    logic [NUM_FN-1:0] fn_hit;
    logic [4:0] fn_pin [NUM_FN];
    logic [NUM_PINS-1:0] pin_hit;
    logic [2:0] pin_fn [NUM_PINS];
    logic crossbar_enable_bit;
    logic take;
    logic commit_wr;
    logic [1:0] word;
    logic [4:0] lane;

    assign crossbar_enable_bit = crossbar_config_third_q[XBE_POS];
    // a request is taken while the slave waits and lands in the answer cycle,
    // so a master that holds its write until then never writes twice
    assign take = (avs_read | avs_write) & (bus_q == BUS_WAIT);
    assign commit_wr = avs_write & (bus_q == BUS_ACK);
    assign word = avs_address[3:2];
    assign lane = {word, 3'b000};

    // ---------------------------------------------
    // helpers
    // ---------------------------------------------
    pxg_pin_sync #(
        .W(NUM_PINS)
    ) u_sync (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .din(pin_in),
        .dout(pin_lvl)
    );

    pxg_xbar_map u_map (
        .en_smb(cfg0_q[CFG0_SMB_POS]),
        .en_spi(cfg0_q[CFG0_SPI_POS]),
        .spi_four(cfg1_q[CFG1_SPI4_POS]),
        .en_uart(cfg0_q[CFG0_UART_POS]),
        .fn_hit(fn_hit),
        .fn_pin(fn_pin),
        .pin_hit(pin_hit),
        .pin_fn(pin_fn)
    );

    // ---------------------------------------------
    // register bus slave
    // ---------------------------------------------
    // a request is seen with waitrequest high, answered one cycle later
    always_comb begin
        bus_d = BUS_WAIT;
        rdata_d = rdata_q;
        latch_d = latch_q;
        mode_d = mode_q;
        cfg0_d = cfg0_q;
        cfg1_d = cfg1_q;
        crossbar_config_third_d = crossbar_config_third_q;
        if (take) begin
            bus_d = BUS_ACK;
            rdata_d = 32'h00000000;
            if (avs_read && avs_address[1:0] == 2'b00) begin
                case (avs_address[6:4])
                    GRP_DATA: begin
                        rdata_d[7:0] = pin_lvl[lane +: 8];
                    end
                    GRP_MODE: begin
                        rdata_d[7:0] = mode_q[lane +: 8];
                    end
                    GRP_LATCH: begin
                        rdata_d[7:0] = latch_q[lane +: 8];
                    end
                    GRP_CFG: begin
                        case (avs_address)
                            OFS_CFG0: rdata_d[7:0] = cfg0_q;
                            OFS_CFG1: rdata_d[7:0] = cfg1_q;
                            OFS_CFG2: rdata_d[7:0] = crossbar_config_third_q;
                            default: rdata_d = 32'h00000000;
                        endcase
                    end
                    default: begin
                        rdata_d = 32'h00000000;
                    end
                endcase
            end
        end
        // writes land at the edge where waitrequest is low
        if (commit_wr && avs_address[1:0] == 2'b00) begin
            case (avs_address[6:4])
                GRP_DATA: begin
                    if (avs_byteenable[0]) begin
                        latch_d[lane +: 8] = avs_writedata[7:0];
                    end
                end
                GRP_LATCH: begin
                    if (avs_byteenable[0]) begin
                        latch_d[lane +: 8] = avs_writedata[7:0];
                    end
                end
                GRP_MODE: begin
                    if (avs_byteenable[0]) begin
                        mode_d[lane +: 8] = avs_writedata[7:0];
                    end
                end
                GRP_CFG: begin
                    if (avs_byteenable[0]) begin
                        case (avs_address)
                            OFS_CFG0: cfg0_d = avs_writedata[7:0];
                            OFS_CFG1: cfg1_d = avs_writedata[7:0];
                            OFS_CFG2: crossbar_config_third_d = avs_writedata[7:0];
                            default: cfg0_d = cfg0_q;
                        endcase
                    end
                end
                GRP_BIT: begin
                    if (avs_address == OFS_BIT && avs_byteenable[1]) begin
                        latch_d[avs_writedata[4:0]] = avs_writedata[BIT_VAL_POS];
                    end
                end
                default: begin
                    latch_d = latch_q;
                end
            endcase
        end
        wait_d = (bus_d != BUS_ACK);
    end

    // bus and configuration registers
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            bus_q <= BUS_WAIT;
            wait_q <= 1'b1;
            rdata_q <= 32'h00000000;
            latch_q <= LATCH_RST;
            mode_q <= MODE_RST;
            cfg0_q <= CFG_RST;
            cfg1_q <= CFG_RST;
            crossbar_config_third_q <= CFG_RST;
        end else begin
            bus_q <= bus_d;
            wait_q <= wait_d;
            rdata_q <= rdata_d;
            latch_q <= latch_d;
            mode_q <= mode_d;
            cfg0_q <= cfg0_d;
            cfg1_q <= cfg1_d;
            crossbar_config_third_q <= crossbar_config_third_d;
        end
    end

    // ---------------------------------------------
    // pin drivers
    // ---------------------------------------------
    // a claimed pin never looks at its latch, so data writes cannot disturb it
    for (genvar p = 0; p < NUM_PINS; p++) begin : g_drv
        logic o;
        logic e;
        logic src;
        // peripheral or latch, then push-pull or open-drain
        always_comb begin
            o = 1'b0;
            e = 1'b0;
            src = fn_out[pin_fn[p]];
            if (!crossbar_enable_bit) begin
                e = 1'b0;
            end else if (pin_hit[p]) begin
                if (FN_INPUT_ONLY[pin_fn[p]]) begin
                    e = 1'b0;
                end else if (mode_q[p]) begin
                    e = fn_oe[pin_fn[p]];
                    o = src;
                end else begin
                    e = fn_oe[pin_fn[p]] & ~src;
                end
            end else if (mode_q[p]) begin
                e = 1'b1;
                o = latch_q[p];
            end else begin
                e = ~latch_q[p];
            end
        end
        assign out_d[p] = o;
        assign oe_d[p] = e;
    end

    // peripheral inputs see the filtered level of their pin
    for (genvar f = 0; f < NUM_FN; f++) begin : g_fin
        assign fin_d[f] = fn_hit[f] ? pin_lvl[fn_pin[f]] : 1'b1;
    end

    // pin and peripheral registers
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            out_q <= '0;
            oe_q <= '0;
            fin_q <= '1;
        end else begin
            out_q <= out_d;
            oe_q <= oe_d;
            fin_q <= fin_d;
        end
    end

    assign avs_readdata = rdata_q;
    assign avs_waitrequest = wait_q;
    assign pin_out = out_q;
    assign pin_oe = oe_q;
    assign fn_in = fin_q;

    // ---------------------------------------------
    // assertions
    // ---------------------------------------------
    gate_off_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        !crossbar_enable_bit |=> (pin_oe == '0))
        else $error("pin driven while crossbar disabled");

    mode_rst_a: assert property (@(posedge ref_clk)
        $fell(sys_rst) |-> (mode_q == '0) && (pin_oe == '0))
        else $error("mode bits not open-drain after reset");

    xbe_rst_a: assert property (@(posedge ref_clk)
        $fell(sys_rst) |-> !crossbar_enable_bit [*2])
        else $error("crossbar enable set after reset");

    uart_gate_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        !cfg0_q[CFG0_UART_POS] |-> !fn_hit[FN_TX] && !fn_hit[FN_RX])
        else $error("disabled uart reached a pin");

    uart_pair_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        fn_hit[FN_TX] |-> fn_hit[FN_RX] && (fn_pin[FN_RX] == fn_pin[FN_TX] + 5'h01))
        else $error("uart signals not paired");

    spi_wire_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        cfg0_q[CFG0_SPI_POS] |-> (fn_hit[FN_SSEL] == cfg1_q[CFG1_SPI4_POS]))
        else $error("slave select wrong for spi mode");

    prio_map_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        cfg0_q[CFG0_SMB_POS] |-> (fn_pin[FN_SDA] == 5'h00) && (pin_fn[1] == FN_SCL))
        else $error("priority order broken");

    rx_float_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        fn_hit[FN_RX] |=> !pin_oe[$past(fn_pin[FN_RX])])
        else $error("receive pin driven");

    pin_read_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (take && avs_read && avs_address == OFS_DATA0)
        |=> !avs_waitrequest && (avs_readdata[7:0] == $past(pin_lvl[7:0])))
        else $error("data read not pin level");

    latch_read_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (take && avs_read && avs_address == OFS_LATCH0 + 7'h04)
        |=> !avs_waitrequest && (avs_readdata[7:0] == $past(latch_q[15:8])))
        else $error("latch read-back wrong");

    byte_wr_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (avs_write && !avs_waitrequest && avs_address == OFS_DATA0 && avs_byteenable[0])
        |=> (latch_q[7:0] == $past(avs_writedata[7:0])))
        else $error("port data write lost");

    periph_out_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (crossbar_enable_bit && pin_hit[0] && mode_q[0] && !FN_INPUT_ONLY[pin_fn[0]])
        |=> (pin_out[0] == $past(fn_out[pin_fn[0]])))
        else $error("claimed pin not from peripheral");

    // the answer follows the taking edge by one cycle and stands for one
    bus_ack_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        take |=> !avs_waitrequest)
        else $error("bus answer late");

    ack_once_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        !avs_waitrequest |=> avs_waitrequest)
        else $error("bus answer held too long");

    // a peripheral on an open-drain pin may only pull low
    periph_od_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (crossbar_enable_bit && pin_hit[0] && !mode_q[0] && !FN_INPUT_ONLY[pin_fn[0]])
        |=> !pin_out[0]
        && (pin_oe[0] == ($past(fn_oe[pin_fn[0]]) && !$past(fn_out[pin_fn[0]]))))
        else $error("open-drain peripheral pin drove high");

    // a function without a pin sees an idle high level
    fin_idle_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        !fn_hit[FN_SDA] |=> fn_in[FN_SDA])
        else $error("unmapped function saw a level");

    for (genvar p = 0; p < NUM_PINS; p++) begin : g_chk
        push_pull_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
            (crossbar_enable_bit && !pin_hit[p] && mode_q[p])
            |=> pin_oe[p] && (pin_out[p] == $past(latch_q[p])))
            else $error("push-pull drive wrong");

        open_drain_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
            (crossbar_enable_bit && !pin_hit[p] && !mode_q[p])
            |=> (pin_oe[p] == !$past(latch_q[p])) && !pin_out[p])
            else $error("open-drain drive wrong");
    end
endmodule

// ===== verification/pxg_pin_model.sv
// external devices on the 32 port pins, with a pull-up on every wire
// assumes the crossbar drives pin_out and pin_oe and reads pin_lvl back
`timescale 1ns/1ps
module pxg_pin_model (
    input wire logic [31:0] pin_out,  // device drive value
    input wire logic [31:0] pin_oe,   // device drive enable
    input wire logic [31:0] ext_low,  // outside device pulls low
    output logic [31:0] pin_lvl       // resolved wire level
);
    // ---------------------------------------------
    // wire resolution
    // ---------------------------------------------
    // wired-and: any low driver wins, a released wire floats up
    assign pin_lvl = ~((pin_oe & ~pin_out) | ext_low);
endmodule

// ===== verification/pxg_port_crossbar_tb_top.sv
// self-checking bench for the port crossbar, register tasks plus pin checks
// assumes pxg_pkg, the crossbar design and the pin model are compiled first
`timescale 1ns/1ps
module pxg_port_crossbar_tb_top;
    import pxg_pkg::*;
    logic ref_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [ADDR_W-1:0] avs_address = '0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = '0;
    logic [3:0] avs_byteenable = '0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic [31:0] pin_lvl, pin_out, pin_oe, ext_low = '0;
    logic [NUM_FN-1:0] fn_out = '0;
    logic [NUM_FN-1:0] fn_oe = '0;
    logic [NUM_FN-1:0] fn_in;
    logic [31:0] rd;
    int miscompares = 0;
    int samples_checked = 0;

    // ---------------------------------------------
    // clock, design and pins
    // ---------------------------------------------
    // 200 MHz system clock
    always #2.5 ref_clk = ~ref_clk;
    pxg_port_crossbar dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .pin_in(pin_lvl), .pin_out(pin_out),
        .pin_oe(pin_oe), .fn_out(fn_out), .fn_oe(fn_oe), .fn_in(fn_in));
    pxg_pin_model pins (.pin_out(pin_out), .pin_oe(pin_oe), .ext_low(ext_low),
        .pin_lvl(pin_lvl));

    // ---------------------------------------------
    // bus tasks and compares
    // ---------------------------------------------
    // waits for the edge that samples waitrequest low
    task automatic wait_ack;
        int n;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        if (n >= 50) begin
            miscompares++;
            $display("ERROR %0t bus answer missing", $time);
        end
    endtask
    task automatic bus_wr(input logic [6:0] a, input logic [31:0] d, input logic [3:0] be);
        avs_address <= a;
        avs_writedata <= d;
        avs_byteenable <= be;
        avs_write <= 1'b1;
        wait_ack();
        avs_write <= 1'b0;
        @(posedge ref_clk);
    endtask
    task automatic bus_rd(input logic [6:0] a, output logic [31:0] d);
        avs_address <= a;
        avs_read <= 1'b1;
        wait_ack();
        d = avs_readdata;
        avs_read <= 1'b0;
        @(posedge ref_clk);
    endtask
    task automatic chk_rd(input logic [6:0] a, input logic [31:0] exp);
        logic [31:0] got;
        bus_rd(a, got);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %0t read %h got %h exp %h", $time, a, got, exp);
        end
    endtask
    task automatic chk_pin(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %0t pins got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    task automatic finish_test;
        if (miscompares == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // ---------------------------------------------
    // watchdog
    // ---------------------------------------------
    // cuts a hang short well past the fewer than 200 cycles the tests need
    initial begin
        repeat (20000) @(posedge ref_clk);
        miscompares++;
        $display("ERROR %0t watchdog expired", $time);
        finish_test();
    end

    // ---------------------------------------------
    // tests
    // ---------------------------------------------
    initial begin
        repeat (6) @(posedge ref_clk);
        sys_rst <= 1'b0;
        @(posedge ref_clk);
        // reset values and an unmapped place
        for (int p = 0; p < 4; p++) begin
            chk_rd(OFS_MODE0 + 7'(4 * p), 32'h00000000);
            chk_rd(OFS_LATCH0 + 7'(4 * p), 32'h000000ff);
        end
        chk_rd(OFS_CFG2, 32'h00000000);
        chk_rd(7'h44, 32'h00000000);
        chk_pin(pin_oe, 32'h00000000);
        // crossbar set up first, drivers still held off
        bus_wr(OFS_MODE0, 32'h000000ff, 4'h1);
        bus_wr(OFS_DATA0, 32'h00000000, 4'h1);
        settle(3);
        chk_pin(pin_oe, 32'h00000000);
        bus_wr(OFS_CFG2, 32'h00000010, 4'h1);
        settle(2);
        chk_pin({16'h0, pin_oe[7:0], pin_out[7:0]}, 32'h0000ff00);
        // push-pull gpio, pin read and latch read
        bus_wr(OFS_DATA0, 32'h000000a5, 4'h1);
        settle(2);
        chk_pin({16'h0, pin_oe[7:0], pin_out[7:0]}, 32'h0000ffa5);
        settle(8);
        chk_rd(OFS_DATA0, 32'h000000a5);
        chk_rd(OFS_LATCH0, 32'h000000a5);
        // open-drain port 1
        bus_wr(OFS_DATA0 + 7'h04, 32'h0000000f, 4'h1);
        settle(2);
        chk_pin({16'h0, pin_oe[15:8], pin_out[15:8]}, 32'h0000f000);
        settle(8);
        chk_rd(OFS_DATA0 + 7'h04, 32'h0000000f);
        ext_low <= 32'h00000100;
        settle(8);
        chk_rd(OFS_DATA0 + 7'h04, 32'h0000000e);
        ext_low <= '0;
        // single-bit writes: pin 12 to one, pin 8 to zero
        bus_wr(OFS_BIT, 32'h0000010c, 4'h2);
        bus_wr(OFS_BIT, 32'h00000008, 4'h2);
        settle(2);
        chk_pin({24'h0, pin_oe[15:8]}, 32'h000000e1);
        chk_rd(OFS_LATCH0 + 7'h04, 32'h0000001e);
        // uart alone: transmit on pin 0, receive on pin 1
        bus_wr(OFS_DATA0, 32'h00000000, 4'h1);
        fn_out <= 8'h40;
        fn_oe <= 8'hff;
        bus_wr(OFS_CFG0, 32'h00000004, 4'h1);
        settle(2);
        chk_pin({26'h0, pin_oe[2:0], pin_out[2:0]}, 32'h00000029);
        ext_low <= 32'h00000002;
        settle(8);
        chk_pin({24'h0, fn_in}, 32'h0000007f);
        chk_rd(OFS_DATA0, 32'h00000001);
        ext_low <= '0;
        // everything enabled, spi in four-wire then three-wire
        fn_out <= 8'h55;
        bus_wr(OFS_CFG1, 32'h00000001, 4'h1);
        bus_wr(OFS_CFG0, 32'h00000007, 4'h1);
        settle(2);
        chk_pin({16'h0, pin_oe[7:0], 1'b0, pin_out[6:0]}, 32'h00007f55);
        bus_wr(OFS_CFG1, 32'h00000000, 4'h1);
        settle(2);
        chk_pin({16'h0, pin_oe[7:0], 2'b0, pin_out[5:0]}, 32'h0000bf35);
        // claimed pins ignore latch writes; open-drain peripherals only pull low
        bus_wr(OFS_DATA0, 32'h000000ff, 4'h1);
        settle(2);
        chk_pin({24'h0, pin_out[7:0]}, 32'h000000b5);
        bus_wr(OFS_MODE0, 32'h00000000, 4'h1);
        settle(2);
        chk_pin({16'h0, pin_oe[7:0], pin_out[7:0]}, 32'h00000a00);
        finish_test();
    end
endmodule
